/* core/mmc_pkg.sv */
// constants and types shared by the module management control block
`default_nettype none

package mmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int CLK_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int CLK_PER_US = CLK_FREQ_HZ / 1_000_000;
  // initialisation deadline after power-on or reset release, in ms
  localparam int INIT_TIME_MS = 2000;
  // longest time rounds down
  localparam int INIT_CYCLES = INIT_TIME_MS * CLK_PER_MS;
  // shortest reset pulse on the reset pin, in ns
  localparam int RESET_MIN_NS = 2000;
  // least time rounds up
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * CLK_PER_US + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // two-wire bus framing
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // memory map
  localparam logic [7:0] ADDR_STATUS2 = 8'h02;
  localparam logic [7:0] ADDR_FLAG_LOS = 8'h03;
  localparam logic [7:0] ADDR_FLAG_FAULT = 8'h04;
  localparam logic [7:0] ADDR_FLAG_MISC = 8'h05;
  localparam logic [7:0] ADDR_CTRL_PWR = 8'h5D;
  localparam logic [7:0] ADDR_MASK_LOS = 8'h64;
  localparam logic [7:0] ADDR_MASK_FAULT = 8'h65;
  localparam logic [7:0] ADDR_MASK_MISC = 8'h66;
  localparam logic [7:0] ADDR_PAGE_SEL = 8'h7F;
  localparam int UPPER_BIT = 7;
  localparam logic [7:0] PAGE_USER = 8'h02;
  localparam int BIT_NOT_READY = 0;
  localparam int BIT_PDOWN = 1;

  ////////////////////////////////////////////////////////////////////////////
  // link protocol states
  typedef enum logic [2:0] {
    MMC_ST_ADDR,
    MMC_ST_PTR,
    MMC_ST_WR,
    MMC_ST_RD,
    MMC_ST_IGN
  } mmc_link_st_t;

endpackage

`default_nettype wire

/* core/mmc_module_ctrl.sv */
// module management control: init, reset filter, flags, masks, two-wire slave
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// two-flop level synchroniser, reused for both directions
module mmc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_q <= '0;
      o_q <= '0;
    end else begin
      meta_q <= i_d;
      o_q <= meta_q;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module mmc_module_ctrl #(
  parameter int CHANNELS = 4,
  parameter int INIT_CYCLES = mmc_pkg::INIT_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_module_reset_low,
  input wire logic i_module_select_low,
  input wire logic i_low_power_select,
  input wire logic [CHANNELS-1:0] i_rx_los,
  input wire logic [CHANNELS-1:0] i_tx_fault,
  input wire logic [7:0] i_misc_cond,
  output logic o_interrupt_out_low_o,
  output logic o_interrupt_out_low_oe,
  output logic o_low_power,
  output logic o_fully_functional
);
  localparam int PIN_W = 5 + 2 * CHANNELS + 8;
  localparam int CFG_W = 2 * CHANNELS + 8 + 2;
  localparam int STS_W = 1 + 2 * CHANNELS + 8;
  localparam int RCW = $clog2(mmc_pkg::RESET_MIN_CYCLES + 1);

  // mclk domain
  logic scl_s, sda_s, rst_pin_s, sel_low_s, lp_s;
  logic [CHANNELS-1:0] los_s, fault_s;
  logic [7:0] misc_s;
  logic [CHANNELS-1:0] mask_los_s, mask_fault_s;
  logic [7:0] mask_misc_s;
  logic pdown_s, crd_tog_s;
  logic [RCW-1:0] rst_cnt_q;
  logic mod_rst_q;
  logic [31:0] init_cnt_q;
  logic not_ready_q, ready_ev_q, init_hit;
  logic crd_prev_q, crd_evt;
  logic [CHANNELS-1:0] los_f_q, fault_f_q, clr_los, clr_fault;
  logic [7:0] misc_f_q, clr_misc;
  logic clr_ready;
  logic sda_prev_q, link_idle_q, restart_q, link_en, start_cond, stop_cond;
  logic irq_d;

  // link (scl) domain
  mmc_pkg::mmc_link_st_t state_q;
  logic [3:0] bit_cnt_q;
  logic [6:0] shreg_q;
  logic ack_q;
  logic [7:0] tx_q, ptr_q, page_q, byte_in, rd_data, crd_addr_q, crd_val_q;
  logic [CHANNELS-1:0] mask_los_q, mask_fault_q, los_sc, fault_sc;
  logic [7:0] mask_misc_q, misc_sc;
  logic pdown_q, crd_tog_q, not_ready_sc;
  logic byte_done, ack_slot, addr_hit, load_rd, wr_en, ptr_set, crd_addr_hit;
  logic [7:0] user_mem [0:127];

  ////////////////////////////////////////////////////////////////////////////
  // pins and link levels into the mclk domain
  mmc_sync #(.W(PIN_W)) u_pin_sync (
    .i_clk(i_mclk),
    .i_nrst(i_nrst),
    .i_d({i_scl, i_sda, i_module_reset_low, i_module_select_low,
          i_low_power_select, i_rx_los, i_tx_fault, i_misc_cond}),
    .o_q({scl_s, sda_s, rst_pin_s, sel_low_s, lp_s, los_s, fault_s, misc_s})
  );

  // software settings from the link domain; quasi-static levels
  mmc_sync #(.W(CFG_W)) u_cfg_sync (
    .i_clk(i_mclk),
    .i_nrst(i_nrst),
    .i_d({mask_los_q, mask_fault_q, mask_misc_q, pdown_q, crd_tog_q}),
    .o_q({mask_los_s, mask_fault_s, mask_misc_s, pdown_s, crd_tog_s})
  );

  // status into the link domain, only sampled while a frame clocks it
  mmc_sync #(.W(STS_W)) u_sts_sync (
    .i_clk(i_scl),
    .i_nrst(i_nrst),
    .i_d({not_ready_q, los_f_q, fault_f_q, misc_f_q}),
    .o_q({not_ready_sc, los_sc, fault_sc, misc_sc})
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset pin filter: only a low longer than the minimum pulse counts
  // reset pulse filter
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_cnt_q <= '0;
      mod_rst_q <= 1'b0;
    end else if (rst_pin_s) begin
      rst_cnt_q <= '0;
      mod_rst_q <= 1'b0;
    end else if (rst_cnt_q != RCW'(mmc_pkg::RESET_MIN_CYCLES)) begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end else begin
      mod_rst_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // initialisation timer, restarted by power-on and by a module reset
  assign init_hit = not_ready_q && (init_cnt_q == 32'(INIT_CYCLES - 1));

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      init_cnt_q <= '0;
      not_ready_q <= 1'b1;
    end else if (mod_rst_q) begin
      init_cnt_q <= '0;
      not_ready_q <= 1'b1;
    end else if (init_hit) begin
      not_ready_q <= 1'b0;
    end else if (not_ready_q) begin
      init_cnt_q <= init_cnt_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clear-on-read: toggle from the link carries a held address and value
  assign crd_evt = crd_tog_s ^ crd_prev_q;

  always_comb begin
    clr_los = '0;
    clr_fault = '0;
    clr_misc = '0;
    clr_ready = 1'b0;
    if (crd_evt) begin
      case (crd_addr_q)
        mmc_pkg::ADDR_STATUS2: clr_ready = 1'b1;
        mmc_pkg::ADDR_FLAG_LOS: clr_los = crd_val_q[CHANNELS-1:0];
        mmc_pkg::ADDR_FLAG_FAULT: clr_fault = crd_val_q[CHANNELS-1:0];
        mmc_pkg::ADDR_FLAG_MISC: clr_misc = crd_val_q;
        default: clr_ready = 1'b0;
      endcase
    end
  end

  // only bits the host actually saw are cleared, so a late event survives
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      crd_prev_q <= 1'b0;
    end else begin
      crd_prev_q <= crd_tog_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags; a set in the clearing cycle wins
  // flag capture
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      los_f_q <= '0;
      fault_f_q <= '0;
      misc_f_q <= '0;
    end else if (mod_rst_q) begin
      los_f_q <= '0;
      fault_f_q <= '0;
      misc_f_q <= '0;
    end else begin
      los_f_q <= (los_f_q & ~clr_los) | los_s;
      fault_f_q <= (fault_f_q & ~clr_fault) | fault_s;
      misc_f_q <= (misc_f_q & ~clr_misc) | misc_s;
    end
  end

  // data-ready event: raised when init ends, released by reading status
  // ready interrupt
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ready_ev_q <= 1'b0;
    end else if (mod_rst_q) begin
      ready_ev_q <= 1'b0;
    end else if (init_hit) begin
      ready_ev_q <= 1'b1;
    end else if (clr_ready) begin
      ready_ev_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt, power level and ready outputs, all registered
  // mask gating
  assign irq_d = (|(los_f_q & ~mask_los_s)) | (|(fault_f_q & ~mask_fault_s)) |
                 (|(misc_f_q & ~mask_misc_s)) | ready_ev_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_interrupt_out_low_o <= 1'b0;
      o_interrupt_out_low_oe <= 1'b0;
      o_low_power <= 1'b0;
      o_fully_functional <= 1'b0;
    end else begin
      o_interrupt_out_low_o <= 1'b0; // open drain only ever pulls low
      o_interrupt_out_low_oe <= irq_d && !mod_rst_q;
      o_low_power <= lp_s || pdown_s;
      o_fully_functional <= !not_ready_q && !mod_rst_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame detection on sampled bus levels; idle holds the link logic reset
  // link gating
  assign link_en = !sel_low_s && !not_ready_q && !mod_rst_q;
  assign start_cond = scl_s && sda_prev_q && !sda_s;
  assign stop_cond = scl_s && !sda_prev_q && sda_s;

  // release of link_idle_q happens with scl high, half a bit before the
  // next scl edge, so the link flops see a clean reset removal
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sda_prev_q <= 1'b1;
      link_idle_q <= 1'b1;
      restart_q <= 1'b0;
    end else begin
      sda_prev_q <= sda_s;
      if (!link_en) begin
        link_idle_q <= 1'b1;
        restart_q <= 1'b0;
      end else if (stop_cond) begin
        link_idle_q <= 1'b1;
        restart_q <= 1'b0;
      end else if (start_cond) begin
        // repeated start: pulse reset for one cycle, then reopen
        link_idle_q <= !link_idle_q;
        restart_q <= !link_idle_q;
      end else if (restart_q) begin
        link_idle_q <= 1'b0;
        restart_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link decode, scl domain
  assign byte_in = {shreg_q, i_sda};
  assign byte_done = bit_cnt_q == {1'b0, mmc_pkg::BIT_LAST};
  assign ack_slot = bit_cnt_q == mmc_pkg::ACK_SLOT;
  assign addr_hit = byte_in[7:1] == mmc_pkg::DEV_ADDR;
  // next read byte is fetched in an ack slot seen low: the address ack or a host ack
  assign load_rd = (state_q == mmc_pkg::MMC_ST_RD) && ack_slot && !i_sda;
  assign wr_en = (state_q == mmc_pkg::MMC_ST_WR) && byte_done;
  assign ptr_set = (state_q == mmc_pkg::MMC_ST_PTR) && byte_done;
  assign crd_addr_hit = (ptr_q == mmc_pkg::ADDR_STATUS2) ||
                        (ptr_q == mmc_pkg::ADDR_FLAG_LOS) ||
                        (ptr_q == mmc_pkg::ADDR_FLAG_FAULT) ||
                        (ptr_q == mmc_pkg::ADDR_FLAG_MISC);

  // read data mux; lower page always visible, upper only for the user page
  // page mapping
  always_comb begin
    rd_data = 8'h00;
    case (ptr_q)
      mmc_pkg::ADDR_STATUS2: rd_data[mmc_pkg::BIT_NOT_READY] = not_ready_sc;
      mmc_pkg::ADDR_FLAG_LOS: rd_data = 8'(los_sc);
      mmc_pkg::ADDR_FLAG_FAULT: rd_data = 8'(fault_sc);
      mmc_pkg::ADDR_FLAG_MISC: rd_data = misc_sc;
      mmc_pkg::ADDR_CTRL_PWR: rd_data[mmc_pkg::BIT_PDOWN] = pdown_q;
      mmc_pkg::ADDR_MASK_LOS: rd_data = 8'(mask_los_q);
      mmc_pkg::ADDR_MASK_FAULT: rd_data = 8'(mask_fault_q);
      mmc_pkg::ADDR_MASK_MISC: rd_data = mask_misc_q;
      mmc_pkg::ADDR_PAGE_SEL: rd_data = page_q;
      default: begin
        if (ptr_q[mmc_pkg::UPPER_BIT] && page_q == mmc_pkg::PAGE_USER) begin
          rd_data = user_mem[ptr_q[6:0]];
        end
      end
    endcase
  end

  // protocol state, cleared between frames by link_idle_q
  always_ff @(posedge i_scl or posedge link_idle_q) begin
    if (link_idle_q) begin
      state_q <= mmc_pkg::MMC_ST_ADDR;
      bit_cnt_q <= '0;
      shreg_q <= '0;
      ack_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      bit_cnt_q <= ack_slot ? 4'h0 : bit_cnt_q + 4'h1;
      shreg_q <= byte_in[6:0];
      if (load_rd) begin
        tx_q <= rd_data;
      end
      case (state_q)
        mmc_pkg::MMC_ST_ADDR: begin
          if (byte_done) begin
            ack_q <= addr_hit;
            if (!addr_hit) begin
              state_q <= mmc_pkg::MMC_ST_IGN;
            end else if (byte_in[0]) begin
              state_q <= mmc_pkg::MMC_ST_RD;
            end else begin
              state_q <= mmc_pkg::MMC_ST_PTR;
            end
          end
        end
        mmc_pkg::MMC_ST_PTR: begin
          if (byte_done) begin
            ack_q <= 1'b1;
            state_q <= mmc_pkg::MMC_ST_WR;
          end
        end
        mmc_pkg::MMC_ST_WR: begin
          if (byte_done) begin
            ack_q <= 1'b1;
          end
        end
        mmc_pkg::MMC_ST_RD: begin
          // ack slot belongs to the host now; its nack ends the read
          ack_q <= 1'b0;
          if (ack_slot && i_sda) begin
            state_q <= mmc_pkg::MMC_ST_IGN;
          end
        end
        mmc_pkg::MMC_ST_IGN: ack_q <= 1'b0;
        default: state_q <= mmc_pkg::MMC_ST_IGN;
      endcase
    end
  end

  // data line drive, set only while scl is low; link_idle_q clears it at any time
  always_ff @(negedge i_scl or posedge link_idle_q) begin
    if (link_idle_q) begin
      o_sda_oe <= 1'b0;
    end else if (ack_slot) begin
      o_sda_oe <= ack_q;
    end else if (state_q == mmc_pkg::MMC_ST_RD) begin
      o_sda_oe <= !tx_q[3'(mmc_pkg::BIT_LAST - bit_cnt_q[2:0])];
    end else begin
      o_sda_oe <= 1'b0;
    end
  end

  // open-drain data: driven value is always low
  always_ff @(negedge i_scl or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sda_o <= 1'b0;
    end else begin
      o_sda_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers kept across frames: pointer, page, masks, power override
  // mask and power writes
  always_ff @(posedge i_scl or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_q <= 8'h00;
      page_q <= 8'h00;
      mask_los_q <= '0;
      mask_fault_q <= '0;
      mask_misc_q <= 8'h00;
      pdown_q <= 1'b0;
    end else begin
      if (ptr_set) begin
        ptr_q <= byte_in;
      end else if (wr_en || load_rd) begin
        ptr_q <= ptr_q + 8'h01;
      end
      if (wr_en) begin
        case (ptr_q)
          mmc_pkg::ADDR_MASK_LOS: mask_los_q <= byte_in[CHANNELS-1:0];
          mmc_pkg::ADDR_MASK_FAULT: mask_fault_q <= byte_in[CHANNELS-1:0];
          mmc_pkg::ADDR_MASK_MISC: mask_misc_q <= byte_in;
          mmc_pkg::ADDR_CTRL_PWR: pdown_q <= byte_in[mmc_pkg::BIT_PDOWN];
          mmc_pkg::ADDR_PAGE_SEL: page_q <= byte_in;
          default: pdown_q <= pdown_q;
        endcase
      end
    end
  end

  // clear-on-read handoff; value held until the next toggle
  // read clear request
  always_ff @(posedge i_scl or negedge i_nrst) begin
    if (!i_nrst) begin
      crd_tog_q <= 1'b0;
      crd_addr_q <= 8'h00;
      crd_val_q <= 8'h00;
    end else if (load_rd && crd_addr_hit) begin
      crd_tog_q <= !crd_tog_q;
      crd_addr_q <= ptr_q;
      crd_val_q <= rd_data;
    end
  end

  // user page storage; no reset, contents are the host's own
  // user page
  always_ff @(posedge i_scl) begin
    if (wr_en && ptr_q[mmc_pkg::UPPER_BIT] && page_q == mmc_pkg::PAGE_USER) begin
      user_mem[ptr_q[6:0]] <= byte_in;
    end
  end

endmodule

`default_nettype wire

/* dv/mmc_ctrl_properties.sv */
// concurrent checks on the module management control ports
`timescale 1ns/1ps
`default_nettype none
module mmc_ctrl_props #(
  parameter int CHANNELS = 4,
  parameter int INIT_CYCLES = mmc_pkg::INIT_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic i_module_reset_low,
  input wire logic i_module_select_low,
  input wire logic i_low_power_select,
  input wire logic [CHANNELS-1:0] i_rx_los,
  input wire logic [CHANNELS-1:0] i_tx_fault,
  input wire logic [7:0] i_misc_cond,
  input wire logic o_interrupt_out_low_o,
  input wire logic o_interrupt_out_low_oe,
  input wire logic o_low_power,
  input wire logic o_fully_functional
);
  int init_cnt_q;
  int low_cnt_q;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////
  // cycles waiting for init; margin covers pin sync and restart
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      init_cnt_q <= 0;
    end else if (o_fully_functional || !i_module_reset_low) begin
      init_cnt_q <= 0;
    end else begin
      init_cnt_q <= init_cnt_q + 1;
    end
  end
  // length of the current reset pin low, saturating to stay small
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_cnt_q <= 0;
    end else if (i_module_reset_low) begin
      low_cnt_q <= 0;
    end else if (low_cnt_q < 1000) begin
      low_cnt_q <= low_cnt_q + 1;
    end
  end
  ////////////////////////////////////////
  sequence seq_lp_rise;
    $rose(i_low_power_select) && o_fully_functional;
  endsequence
  sequence seq_long_low;
    low_cnt_q == 115;
  endsequence
  lp_enter_a: assert property (seq_lp_rise |-> ##[1:6] o_low_power)
    else $error("low power not entered after pin rise");
  init_bound_a: assert property (init_cnt_q <= INIT_CYCLES + 16)
    else $error("init took too long");
  ready_int_a: assert property ($rose(o_fully_functional) |-> o_interrupt_out_low_oe)
    else $error("ready without interrupt");
  reset_filter_a: assert property ($fell(o_fully_functional) |-> low_cnt_q >= 100)
    else $error("short reset pulse taken");
  reset_take_a: assert property (seq_long_low |-> !o_fully_functional)
    else $error("long reset pulse ignored");
  int_drop_a: assert property ($fell(o_fully_functional) |-> ##[0:2] !o_interrupt_out_low_oe)
    else $error("interrupt held in module reset");
  desel_quiet_a: assert property (i_module_select_low [*8] |-> !o_sda_oe)
    else $error("bus driven while deselected");
  notready_quiet_a: assert property (!o_fully_functional [*4] |-> !o_sda_oe)
    else $error("bus driven before ready");
  pin_low_only_a: assert property (!o_sda_o && !o_interrupt_out_low_o)
    else $error("open drain value not low");
endmodule

bind mmc_module_ctrl mmc_ctrl_props #(.CHANNELS(CHANNELS), .INIT_CYCLES(INIT_CYCLES)) u_props (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_module_reset_low(i_module_reset_low),
  .i_module_select_low(i_module_select_low), .i_low_power_select(i_low_power_select),
  .i_rx_los(i_rx_los), .i_tx_fault(i_tx_fault), .i_misc_cond(i_misc_cond),
  .o_interrupt_out_low_o(o_interrupt_out_low_o),
  .o_interrupt_out_low_oe(o_interrupt_out_low_oe),
  .o_low_power(o_low_power), .o_fully_functional(o_fully_functional)
);
`default_nettype wire

/* dv/mmc_host_model.sv */
// host side of the two-wire bus: clock master and data driver
`timescale 1ns/1ps
`default_nettype none
module mmc_host_model (
  output var logic o_scl,
  output var logic o_sda,
  input wire logic i_sda
);
  // phase length; above four system clocks, off the 20 ns grid
  localparam int H = 97;
  // clock stands high and data released outside frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  ////////////////////////////////////////
  // start, also used as repeated start from clock low
  task automatic start();
    o_sda = 1'b1;
    #H;
    o_scl = 1'b1;
    #H;
    o_sda = 1'b0;
    #H;
    o_scl = 1'b0;
  endtask
  task automatic stop();
    #20;
    o_sda = 1'b0;
    #H;
    o_scl = 1'b1;
    #H;
    o_sda = 1'b1;
    #H;
  endtask
  // data moves only while clock low, a little after the fall
  task automatic bit_io(input logic b, output logic r);
    #20;
    o_sda = b;
    #H;
    o_scl = 1'b1;
    #H;
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
  endtask
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    wbyte({mmc_pkg::DEV_ADDR, 1'b0}, k0);
    wbyte(a, k1);
    wbyte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  // random read: pointer write, repeated start, one byte, host nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    wbyte({mmc_pkg::DEV_ADDR, 1'b0}, k0);
    wbyte(a, k1);
    start();
    wbyte({mmc_pkg::DEV_ADDR, 1'b1}, k2);
    rbyte(d);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule
`default_nettype wire

/* dv/mmc_module_ctrl_tb.sv */
// self-checking bench for the module management control block
`timescale 1ns/1ps
`default_nettype none
module mmc_module_ctrl_tb;
  // short init keeps the run small; the ready wait derives from it
  localparam int INIT = 1000;
  logic i_mclk, i_nrst, i_module_reset_low, i_module_select_low, i_low_power_select;
  logic [3:0] i_rx_los, i_tx_fault;
  logic [7:0] i_misc_cond, rd_data;
  logic scl, host_sda, sda, sda_o, sda_oe, int_o, int_oe, low_power, ff, ok;
  logic [7:0] addr_tab [3] = '{mmc_pkg::ADDR_FLAG_LOS, mmc_pkg::ADDR_FLAG_FAULT,
                               mmc_pkg::ADDR_FLAG_MISC};
  logic [7:0] exp_tab [3] = '{8'h02, 8'h04, 8'h80};
  int miscompares, checked;
  // pulled-up wire: low when either side pulls
  assign sda = host_sda & ~sda_oe;
  mmc_host_model host (.o_scl(scl), .o_sda(host_sda), .i_sda(sda));
  mmc_module_ctrl #(.CHANNELS(4), .INIT_CYCLES(INIT)) DUT (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_module_reset_low(i_module_reset_low),
    .i_module_select_low(i_module_select_low), .i_low_power_select(i_low_power_select),
    .i_rx_los(i_rx_los), .i_tx_fault(i_tx_fault), .i_misc_cond(i_misc_cond),
    .o_interrupt_out_low_o(int_o), .o_interrupt_out_low_oe(int_oe),
    .o_low_power(low_power), .o_fully_functional(ff)
  );
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////
  // wait then step off the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait for the ready output
  task automatic wait_ff();
    int n;
    n = 0;
    while (ff !== 1'b1 && n < INIT + 100) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic results();
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // the whole sequence needs about 8k cycles
  initial begin
    repeat (60000) @(posedge i_mclk);
    miscompares++;
    results();
  end
  ////////////////////////////////////////
  initial begin
    i_nrst = 1'b0;
    i_module_reset_low = 1'b1;
    i_module_select_low = 1'b0;
    i_low_power_select = 1'b0;
    i_rx_los = 4'h0;
    i_tx_fault = 4'h0;
    i_misc_cond = 8'h00;
    repeat (5) @(posedge i_mclk);
    i_nrst <= 1'b1;
    cyc(2);
    chk_bit(int_oe, 1'b0);
    host.wr(mmc_pkg::ADDR_MASK_MISC, 8'h00, ok);
    chk_bit(ok, 1'b0);
    wait_ff();
    chk_bit(ff, 1'b1);
    chk_bit(int_oe, 1'b1);
    host.rd(mmc_pkg::ADDR_STATUS2, rd_data, ok);
    chk_bit(ok, 1'b1);
    chk_bit(rd_data[0], 1'b0);
    cyc(10);
    chk_bit(int_oe, 1'b0);
    // signal loss, transmit fault and misc flag, each sticky until read
    for (int k = 0; k < 3; k++) begin
      @(posedge i_mclk);
      i_rx_los <= (k == 0) ? 4'h2 : 4'h0;
      i_tx_fault <= (k == 1) ? 4'h4 : 4'h0;
      i_misc_cond <= (k == 2) ? 8'h80 : 8'h00;
      cyc(8);
      chk_bit(int_oe, 1'b1);
      @(posedge i_mclk);
      i_rx_los <= 4'h0;
      i_tx_fault <= 4'h0;
      i_misc_cond <= 8'h00;
      cyc(8);
      chk_bit(int_oe, 1'b1);
      host.rd(addr_tab[k], rd_data, ok);
      chk_byte(rd_data, exp_tab[k]);
      cyc(10);
      chk_bit(int_oe, 1'b0);
    end
    host.wr(mmc_pkg::ADDR_MASK_LOS, 8'h01, ok);
    @(posedge i_mclk);
    i_rx_los <= 4'h1;
    cyc(10);
    chk_bit(int_oe, 1'b0);
    host.wr(mmc_pkg::ADDR_MASK_LOS, 8'h00, ok);
    cyc(10);
    chk_bit(int_oe, 1'b1);
    @(posedge i_mclk);
    i_rx_los <= 4'h0;
    cyc(8);
    host.rd(mmc_pkg::ADDR_FLAG_LOS, rd_data, ok);
    chk_byte(rd_data, 8'h01);
    cyc(10);
    chk_bit(int_oe, 1'b0);
    @(posedge i_mclk);
    i_low_power_select <= 1'b1;
    cyc(6);
    chk_bit(low_power, 1'b1);
    @(posedge i_mclk);
    i_low_power_select <= 1'b0;
    cyc(6);
    chk_bit(low_power, 1'b0);
    host.wr(mmc_pkg::ADDR_CTRL_PWR, 8'h02, ok);
    cyc(6);
    chk_bit(low_power, 1'b1);
    host.wr(mmc_pkg::ADDR_CTRL_PWR, 8'h00, ok);
    cyc(6);
    chk_bit(low_power, 1'b0);
    chk_bit(ff, 1'b1);
    host.wr(mmc_pkg::ADDR_PAGE_SEL, mmc_pkg::PAGE_USER, ok);
    host.wr(8'h80, 8'hA5, ok);
    host.rd(8'h80, rd_data, ok);
    chk_byte(rd_data, 8'hA5);
    host.rd(mmc_pkg::ADDR_PAGE_SEL, rd_data, ok);
    chk_byte(rd_data, 8'h02);
    @(posedge i_mclk);
    i_module_select_low <= 1'b1;
    cyc(8);
    host.wr(mmc_pkg::ADDR_MASK_MISC, 8'hFF, ok);
    chk_bit(ok, 1'b0);
    @(posedge i_mclk);
    i_module_select_low <= 1'b0;
    cyc(8);
    host.rd(mmc_pkg::ADDR_MASK_MISC, rd_data, ok);
    chk_bit(ok, 1'b1);
    chk_byte(rd_data, 8'h00);
    // short pulse is filtered, long one restarts init
    @(posedge i_mclk);
    i_module_reset_low <= 1'b0;
    cyc(60);
    @(posedge i_mclk);
    i_module_reset_low <= 1'b1;
    cyc(10);
    chk_bit(ff, 1'b1);
    // host holds pin low past the minimum
    @(posedge i_mclk);
    i_module_reset_low <= 1'b0;
    cyc(150);
    chk_bit(ff, 1'b0);
    chk_bit(int_oe, 1'b0);
    @(posedge i_mclk);
    i_module_reset_low <= 1'b1;
    wait_ff();
    chk_bit(ff, 1'b1);
    chk_bit(int_oe, 1'b1);
    results();
  end
endmodule
`default_nettype wire
